// ===== rtl/msc_supervisor.sv
// Added by the designer: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module msc_supervisor import msc_pkg::*; (
   input wire logic ref_clk,
   input wire logic rstn,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Motor side observations
   input wire logic zcEvent,
   input wire logic motorDriven,
   input wire logic closedLoop,
   input wire logic openLoop,
   input wire logic [11:0] phaseCurrent,
   input wire logic [11:0] backEmfLevel,
   input wire logic [8:0] supplyVoltage,
   input wire logic [11:0] speedInput,
   input wire logic [11:0] sense_amp_out_a,
   input wire logic [11:0] sense_amp_out_b,
   input wire logic [11:0] sense_amp_out_c,
   input wire logic dirPin,
   input wire logic brakePin,
   // Controls and indications
   output logic dirCounterClockwise,
   output logic brakeActive,
   output logic [11:0] monitor_dac_a,
   output logic [11:0] monitor_dac_b,
   output logic speed_pulse_out,
   output logic motorOutEnable,
   output logic chargePumpEnable,
   output logic analog_regulator,
   output logic serialEnable,
   output logic faultAny
);
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] speedCfg;
      logic [31:0] absentCfg;
      logic [31:0] supplyCfg;
      logic [31:0] sleepTime;
      logic [31:0] pulseCfg;
      logic [31:0] syncTimeout;
      logic [31:0] monitorSel;
      logic [FLT_COUNT-1:0] faults;
      logic [23:0] periodCnt;
      logic [23:0] period;
      logic periodValid;
      logic [31:0] sleepCnt;
      msc_power_type pwr;
      logic ack;
      logic [31:0] rdata;
      logic [11:0] dacA;
      logic [11:0] dacB;
      logic pulseOut;
   } msc_state_type;

   msc_state_type s_q, s_d;
   logic pulseLevel;
   logic pulseRun;
   logic [1:0] dirOvr, brakeOvr, loopSel, bSrc;
   logic [8:0] lowLimit, highLimit;
   logic [7:0] absentPct;
   logic [11:0] baseCurrent;
   logic [19:0] currentScaled, absentLimit;
   logic lowCond, highCond, absentCond, overspeedEvt, syncLostCond;
   logic loopOk, pulseActive, wbReq, wbWrite;
   logic [FLT_COUNT-1:0] faultClr;

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   // Byte-lane merge of a Wishbone write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                         input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[8*i +: 8] = wr[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Clamp a configured limit into its legal range
   function automatic logic [8:0] clamp(input logic [8:0] v, input logic [8:0] lo,
                                        input logic [8:0] hi);
      logic [8:0] res;
      res = v;
      if (v < lo) begin
         res = lo;
      end else if (v > hi) begin
         res = hi;
      end
      return res;
   endfunction

   // Monitor variable lookup by address
   function automatic logic [11:0] varPick(input logic [11:0] addr, input logic [23:0] per,
                                           input logic [11:0] cur, input logic [8:0] vs,
                                           input logic [11:0] spd, input logic [11:0] bemf);
      logic [11:0] res;
      res = 12'h000;
      unique case (addr)
         VAR_PERIOD: res = (per[23:12] != 12'h000) ? 12'hFFF : per[11:0];
         VAR_CURRENT: res = cur;
         VAR_SUPPLY: res = {3'h0, vs};
         VAR_SPEED_IN: res = spd;
         VAR_BACKEMF: res = bemf;
         default: res = 12'h000;
      endcase
      return res;
   endfunction

   // --------------------------------------------------------------
   // Configuration decode
   // --------------------------------------------------------------
   // Field slices of the configuration registers
   assign dirOvr = s_q.ctrl[CTRL_DIR_LSB +: 2];
   assign brakeOvr = s_q.ctrl[CTRL_BRAKE_LSB +: 2];
   assign loopSel = s_q.ctrl[CTRL_LOOP_LSB +: 2];
   assign bSrc = s_q.ctrl[CTRL_BSRC_LSB +: 2];
   assign lowLimit = clamp(s_q.supplyCfg[8:0], SUPPLY_LOW_MIN, SUPPLY_LOW_MAX);
   assign highLimit = clamp(s_q.supplyCfg[24:16], SUPPLY_HIGH_MIN, SUPPLY_HIGH_MAX);
   assign absentPct = s_q.absentCfg[7:0];
   assign baseCurrent = s_q.absentCfg[27:16];

   // --------------------------------------------------------------
   // Fault conditions
   // --------------------------------------------------------------
   // Current times 100 against percent of base current
   assign currentScaled = 20'(phaseCurrent) * 20'h0_0064;
   assign absentLimit = 20'(absentPct) * 20'(baseCurrent);
   assign absentCond = motorDriven && (currentScaled < absentLimit);
   // Shorter interval than threshold means speed above threshold
   assign overspeedEvt = zcEvent && s_q.periodValid
                         && ({s_q.periodCnt} < s_q.speedCfg[23:0]);
   // No crossing within timeout while driving; also catches open phases
   assign syncLostCond = motorDriven && (32'(s_q.periodCnt) >= s_q.syncTimeout);
   assign lowCond = supplyVoltage < lowLimit;
   assign highCond = supplyVoltage > highLimit;

   // --------------------------------------------------------------
   // Bus decode
   // --------------------------------------------------------------
   // Write takes effect on the edge that carries ack
   assign wbReq = wb_cyc_i && wb_stb_i;
   assign wbWrite = wbReq && wb_we_i && s_q.ack;
   assign faultClr = (wbWrite && wb_adr_i == REG_FAULT && wb_sel_i[0])
                     ? wb_dat_i[FLT_COUNT-1:0] : '0;

   // --------------------------------------------------------------
   // Speed pulse gating
   // --------------------------------------------------------------
   // Loop select and pulse mode decide when the divider runs
   always_comb begin
      unique case (loopSel)
         LOOP_BOTH: loopOk = closedLoop || openLoop;
         LOOP_OPEN: loopOk = openLoop;
         default: loopOk = closedLoop;
      endcase
      if (s_q.ctrl[CTRL_PULSE_MODE]) begin
         pulseActive = loopOk && (backEmfLevel >= s_q.pulseCfg[19:8]);
      end else begin
         pulseActive = loopOk && motorDriven;
      end
   end
   assign pulseRun = pulseActive && (s_q.pwr == PWR_RUN);

   msc_pulse_div u_div (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .zcEvent(zcEvent),
      .divider(s_q.pulseCfg[7:0]),
      .run(pulseRun),
      .pulseLevel(pulseLevel)
   );

   // --------------------------------------------------------------
   // Next-state logic
   // --------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // Single-wait-state ack, dropped the cycle after it is given
      s_d.ack = wbReq && !s_q.ack;
      if (wbReq && !s_q.ack) begin
         unique case (wb_adr_i)
            REG_CTRL: s_d.rdata = s_q.ctrl;
            REG_SPEED_CFG: s_d.rdata = s_q.speedCfg;
            REG_ABSENT_CFG: s_d.rdata = s_q.absentCfg;
            REG_SUPPLY_CFG: s_d.rdata = s_q.supplyCfg;
            REG_SLEEP_TIME: s_d.rdata = s_q.sleepTime;
            REG_PULSE_CFG: s_d.rdata = s_q.pulseCfg;
            REG_SYNC_TIMEOUT: s_d.rdata = s_q.syncTimeout;
            REG_MONITOR_SEL: s_d.rdata = s_q.monitorSel;
            REG_FAULT: s_d.rdata = 32'(s_q.faults);
            REG_PERIOD: s_d.rdata = {7'h00, s_q.periodValid, s_q.period};
            REG_STATUS: s_d.rdata = {28'h000_0000, s_q.pwr, faultAny};
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      // Configuration writes
      if (wbWrite) begin
         unique case (wb_adr_i)
            REG_CTRL: s_d.ctrl = merge(s_q.ctrl, wb_dat_i, wb_sel_i);
            REG_SPEED_CFG: s_d.speedCfg = merge(s_q.speedCfg, wb_dat_i, wb_sel_i);
            REG_ABSENT_CFG: s_d.absentCfg = merge(s_q.absentCfg, wb_dat_i, wb_sel_i);
            REG_SUPPLY_CFG: s_d.supplyCfg = merge(s_q.supplyCfg, wb_dat_i, wb_sel_i);
            REG_SLEEP_TIME: s_d.sleepTime = merge(s_q.sleepTime, wb_dat_i, wb_sel_i);
            REG_PULSE_CFG: s_d.pulseCfg = merge(s_q.pulseCfg, wb_dat_i, wb_sel_i);
            REG_SYNC_TIMEOUT: s_d.syncTimeout = merge(s_q.syncTimeout, wb_dat_i, wb_sel_i);
            REG_MONITOR_SEL: s_d.monitorSel = merge(s_q.monitorSel, wb_dat_i, wb_sel_i);
            default: s_d.ctrl = s_q.ctrl;
         endcase
      end

      // Interval between crossings, saturating counter
      if (zcEvent) begin
         s_d.period = s_q.periodCnt;
         s_d.periodValid = 1'b1;
         s_d.periodCnt = 24'h00_0001;
      end else if (s_q.periodCnt != 24'hFF_FFFF) begin
         s_d.periodCnt = s_q.periodCnt + 24'h00_0001;
      end

      // Sticky faults (supply low/high only with CTRL_UV_LATCH/CTRL_OV_LATCH set): write-one clears, a new event wins
      s_d.faults = s_q.faults & ~faultClr;
      if (overspeedEvt) begin
         s_d.faults[FLT_OVERSPEED] = 1'b1;
      end
      if (syncLostCond) begin
         s_d.faults[FLT_SYNC_LOST] = 1'b1;
      end
      if (absentCond) begin
         s_d.faults[FLT_ABSENT] = 1'b1;
      end
      if (lowCond) begin
         s_d.faults[FLT_SUPPLY_LOW] = 1'b1;
      end else if (!s_q.ctrl[CTRL_UV_LATCH]) begin
         s_d.faults[FLT_SUPPLY_LOW] = 1'b0;
      end
      if (highCond) begin
         s_d.faults[FLT_SUPPLY_HIGH] = 1'b1;
      end else if (!s_q.ctrl[CTRL_OV_LATCH]) begin
         s_d.faults[FLT_SUPPLY_HIGH] = 1'b0;
      end

      // Low-power entry after a continuous low speed command
      if (speedInput >= {s_q.speedCfg[31:24], 4'h0}) begin
         s_d.sleepCnt = 32'h0000_0000;
         s_d.pwr = PWR_RUN;
      end else begin
         unique case (s_q.pwr)
            PWR_RUN: begin
               if (s_q.sleepCnt + 32'h0000_0001 >= s_q.sleepTime) begin
                  s_d.pwr = s_q.ctrl[CTRL_SLEEP_SEL] ? PWR_SLEEP : PWR_STANDBY;
               end else begin
                  s_d.sleepCnt = s_q.sleepCnt + 32'h0000_0001;
               end
            end
            PWR_STANDBY: s_d.pwr = PWR_STANDBY;
            PWR_SLEEP: s_d.pwr = PWR_SLEEP;
            default: s_d.pwr = PWR_RUN;
         endcase
      end

      // Monitor channels, refreshed every cycle without bus traffic
      s_d.dacA = varPick(s_q.monitorSel[11:0], s_q.period, phaseCurrent, supplyVoltage,
                         speedInput, backEmfLevel);
      unique case (bSrc)
         BSRC_SENSE_A: s_d.dacB = sense_amp_out_a;
         BSRC_SENSE_B: s_d.dacB = sense_amp_out_b;
         BSRC_SENSE_C: s_d.dacB = sense_amp_out_c;
         default: s_d.dacB = varPick(s_q.monitorSel[27:16], s_q.period, phaseCurrent,
                                     supplyVoltage, speedInput, backEmfLevel);
      endcase

      // Speed pulse: released high when not running, low when idle
      if (s_q.pwr != PWR_RUN) begin
         s_d.pulseOut = 1'b1;
      end else begin
         s_d.pulseOut = pulseActive && pulseLevel;
      end
   end

   // --------------------------------------------------------------
   // State register
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s_q.ctrl <= RST_CTRL;
         s_q.speedCfg <= RST_SPEED_CFG;
         s_q.absentCfg <= RST_ABSENT_CFG;
         s_q.supplyCfg <= RST_SUPPLY_CFG;
         s_q.sleepTime <= RST_SLEEP_TIME;
         s_q.pulseCfg <= RST_PULSE_CFG;
         s_q.syncTimeout <= RST_SYNC_TIMEOUT;
         s_q.monitorSel <= RST_MONITOR_SEL;
         s_q.faults <= '0;
         s_q.periodCnt <= 24'h00_0000;
         s_q.period <= 24'h00_0000;
         s_q.periodValid <= 1'b0;
         s_q.sleepCnt <= 32'h0000_0000;
         s_q.pwr <= PWR_RUN;
         s_q.ack <= 1'b0;
         s_q.rdata <= 32'h0000_0000;
         s_q.dacA <= 12'h000;
         s_q.dacB <= 12'h000;
         s_q.pulseOut <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // --------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------
   // Direction and brake pins with overrides
   always_comb begin
      unique case (dirOvr)
         OVR_FORCE_ON: dirCounterClockwise = 1'b0;
         OVR_FORCE_OFF: dirCounterClockwise = 1'b1;
         default: dirCounterClockwise = dirPin;
      endcase
      unique case (brakeOvr)
         OVR_FORCE_ON: brakeActive = 1'b1;
         OVR_FORCE_OFF: brakeActive = 1'b0;
         default: brakeActive = brakePin;
      endcase
   end

   // Power gating: sleep shuts drivers, pump, regulator and serial link
   assign motorOutEnable = (s_q.pwr == PWR_RUN);
   assign chargePumpEnable = (s_q.pwr != PWR_SLEEP);
   assign analog_regulator = (s_q.pwr != PWR_SLEEP);
   assign serialEnable = (s_q.pwr != PWR_SLEEP);
   assign faultAny = |s_q.faults;
   assign monitor_dac_a = s_q.dacA;
   assign monitor_dac_b = s_q.dacB;
   assign speed_pulse_out = s_q.pulseOut;
   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdata;
endmodule // msc_supervisor

// ===== rtl/msc_pkg.sv
package msc_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SPEED_CFG = 8'h04;
   localparam logic [7:0] REG_ABSENT_CFG = 8'h08;
   localparam logic [7:0] REG_SUPPLY_CFG = 8'h0C;
   localparam logic [7:0] REG_SLEEP_TIME = 8'h10;
   localparam logic [7:0] REG_PULSE_CFG = 8'h14;
   localparam logic [7:0] REG_SYNC_TIMEOUT = 8'h18;
   localparam logic [7:0] REG_MONITOR_SEL = 8'h1C;
   localparam logic [7:0] REG_FAULT = 8'h20;
   localparam logic [7:0] REG_PERIOD = 8'h24;
   localparam logic [7:0] REG_STATUS = 8'h28;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTRL_DIR_LSB = 0;
   localparam int CTRL_BRAKE_LSB = 2;
   localparam int CTRL_LOOP_LSB = 4;
   localparam int CTRL_PULSE_MODE = 6;
   localparam int CTRL_UV_LATCH = 7;
   localparam int CTRL_OV_LATCH = 8;
   localparam int CTRL_BSRC_LSB = 10;
   localparam int CTRL_SLEEP_SEL = 12;

   // Override codes for direction and brake fields
   localparam logic [1:0] OVR_FORCE_ON = 2'h1;
   localparam logic [1:0] OVR_FORCE_OFF = 2'h2;

   // Loop select codes
   localparam logic [1:0] LOOP_CLOSED = 2'h0;
   localparam logic [1:0] LOOP_BOTH = 2'h1;
   localparam logic [1:0] LOOP_OPEN = 2'h2;

   // Monitor B pin sources
   localparam logic [1:0] BSRC_DAC = 2'h0;
   localparam logic [1:0] BSRC_SENSE_A = 2'h1;
   localparam logic [1:0] BSRC_SENSE_B = 2'h2;
   localparam logic [1:0] BSRC_SENSE_C = 2'h3;

   // Fault bit positions
   localparam int FLT_OVERSPEED = 0;
   localparam int FLT_SYNC_LOST = 1;
   localparam int FLT_ABSENT = 2;
   localparam int FLT_SUPPLY_LOW = 3;
   localparam int FLT_SUPPLY_HIGH = 4;
   localparam int FLT_COUNT = 5;

   // Monitor variable addresses
   localparam logic [11:0] VAR_PERIOD = 12'h0000;
   localparam logic [11:0] VAR_CURRENT = 12'h0001;
   localparam logic [11:0] VAR_SUPPLY = 12'h0002;
   localparam logic [11:0] VAR_SPEED_IN = 12'h0003;
   localparam logic [11:0] VAR_BACKEMF = 12'h0004;

   // Monitor DAC: 12-bit code, full scale 3000 mV
   localparam int DAC_BITS = 12;
   localparam int DAC_FULL_SCALE_MV = 3000;

   // Supply limit ranges, units of 100 mV
   localparam logic [8:0] SUPPLY_LOW_MIN = 9'h02D;
   localparam logic [8:0] SUPPLY_LOW_MAX = 9'h07D;
   localparam logic [8:0] SUPPLY_HIGH_MIN = 9'h0C8;
   localparam logic [8:0] SUPPLY_HIGH_MAX = 9'h15E;

   // Reset values
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_SPEED_CFG = 32'h0000_0100;
   localparam logic [31:0] RST_ABSENT_CFG = 32'h0800_0005;
   localparam logic [31:0] RST_SUPPLY_CFG = 32'h0000_FA2D;
   localparam logic [31:0] RST_SLEEP_TIME = 32'h000F_4240;
   localparam logic [31:0] RST_PULSE_CFG = 32'h0000_0001;
   localparam logic [31:0] RST_SYNC_TIMEOUT = 32'h000F_4240;
   localparam logic [31:0] RST_MONITOR_SEL = 32'h0000_0000;

   // Power states
   typedef enum logic [2:0] {
      PWR_RUN = 3'b001,
      PWR_STANDBY = 3'b010,
      PWR_SLEEP = 3'b100
   } msc_power_type;
endpackage

// ===== rtl/msc_pulse_div.sv
`timescale 1ns/1ps
// Divides zero-crossing events into a square speed pulse
module msc_pulse_div import msc_pkg::*; (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic zcEvent,
   input wire logic [7:0] divider,
   input wire logic run,
   output logic pulseLevel
);
   typedef struct packed {
      logic [7:0] cnt;
      logic level;
   } msc_div_type;

   msc_div_type s_q, s_d;

   // --------------------------------------------------------------
   // Event counter, toggles level once per divider events
   // --------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (!run) begin
         s_d.cnt = 8'h00;
         s_d.level = 1'b0;
      end else if (zcEvent) begin
         if (s_q.cnt + 8'h01 >= divider) begin // Divider 0 acts as 1
            s_d.cnt = 8'h00;
            s_d.level = ~s_q.level;
         end else begin
            s_d.cnt = s_q.cnt + 8'h01;
         end
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pulseLevel = s_q.level;
endmodule // msc_pulse_div

// ===== dv/msc_checker.sv
`timescale 1ns/1ps
// Watches bus timing, fault indication and power-state outputs
module msc_checker (
   input logic ref_clk,
   input logic rstn,
   input logic wb_cyc_i,
   input logic wb_stb_i,
   input logic wb_ack_o,
   input logic [8:0] supplyVoltage,
   input logic motorOutEnable,
   input logic chargePumpEnable,
   input logic analog_regulator,
   input logic serialEnable,
   input logic speed_pulse_out,
   input logic faultAny
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   a_ack_bounded: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |-> ##[1:2] wb_ack_o)
      else $error("ack did not follow request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   // ----------------------------------------------------------------
   // Faults and power states
   // ----------------------------------------------------------------
   a_low_supply: assert property ((supplyVoltage < 9'h02D) |-> ##[1:2] faultAny)
      else $error("low supply not flagged");
   a_high_supply: assert property ((supplyVoltage > 9'h15E) |-> ##[1:2] faultAny)
      else $error("high supply not flagged");
   a_sleep_all: assert property (!serialEnable |-> !motorOutEnable && !chargePumpEnable && !analog_regulator)
      else $error("sleep left a supply enabled");
   a_idle_pulse: assert property ((!motorOutEnable && $past(!motorOutEnable)) |-> speed_pulse_out)
      else $error("speed pulse not released high");
   a_reset_run: assert property ($rose(rstn) |-> motorOutEnable && serialEnable && !wb_ack_o)
      else $error("not running after reset");
endmodule // msc_checker

bind msc_supervisor msc_checker u_msc_checker (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .supplyVoltage, .motorOutEnable, .chargePumpEnable, .analog_regulator,
   .serialEnable, .speed_pulse_out, .faultAny);

// ===== dv/msc_motor_model.sv
`timescale 1ns/1ps
// Motor stand-in: one zero crossing every period cycles while spinning
module msc_motor_model (
   input logic ref_clk,
   input logic rstn,
   input logic spinning,
   input logic [15:0] period,
   output logic zcEvent,
   output logic [11:0] backEmfLevel
);
   logic [15:0] count_q;
   // Crossing spacing sets the measured speed
   always_ff @(posedge ref_clk) begin
      if (!rstn || !spinning || count_q == period - 16'h0001) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + 16'h0001;
      end
      zcEvent <= rstn && spinning && count_q == period - 16'h0001;
   end
   // Back-EMF collapses when the rotor stops
   assign backEmfLevel = spinning ? 12'h0200 : 12'h0010;
endmodule // msc_motor_model

// ===== dv/msc_supervisor_test.sv
`timescale 1ns/1ps
module msc_supervisor_test import msc_pkg::*;;
   logic ref_clk = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, zcEvent;
   logic [7:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = '0;
   logic [31:0] wb_dat_i = '0, wb_dat_o;
   logic motorDriven = 1, closedLoop = 1, openLoop = 0, dirPin = 0, brakePin = 0, spinning = 1;
   logic [11:0] phaseCurrent = 12'h01F4, backEmfLevel, speedInput = 12'h0064;
   logic [11:0] sense_amp_out_a, sense_amp_out_b, sense_amp_out_c, monitor_dac_a, monitor_dac_b;
   logic [8:0] supplyVoltage = 9'h0B4;
   logic dirCounterClockwise, brakeActive, speed_pulse_out, motorOutEnable, chargePumpEnable;
   logic analog_regulator, serialEnable, faultAny, prevPulse = 0;
   logic [31:0] expQ [$];
   int n_fail = 0, cmp_count = 0, seed = 25, tog = 0, cycles = 0;
   localparam logic [31:0] RV [8] = '{RST_CTRL, RST_SPEED_CFG, RST_ABSENT_CFG, RST_SUPPLY_CFG,
      RST_SLEEP_TIME, RST_PULSE_CFG, RST_SYNC_TIMEOUT, RST_MONITOR_SEL};

   msc_supervisor u_msc_supervisor (.ref_clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .zcEvent, .motorDriven, .closedLoop, .openLoop,
      .phaseCurrent, .backEmfLevel, .supplyVoltage, .speedInput, .sense_amp_out_a,
      .sense_amp_out_b, .sense_amp_out_c, .dirPin, .brakePin, .dirCounterClockwise, .brakeActive,
      .monitor_dac_a, .monitor_dac_b, .speed_pulse_out, .motorOutEnable, .chargePumpEnable,
      .analog_regulator, .serialEnable, .faultAny);
   msc_motor_model u_msc_motor_model (.ref_clk, .rstn, .spinning, .period(16'h012C), .zcEvent,
      .backEmfLevel);

   // Clock
   always #5 ref_clk = ~ref_clk;

   // Read-data scoreboard, pulse edge count and hang guard
   always @(posedge ref_clk) begin
      cycles++;
      prevPulse <= speed_pulse_out;
      if (speed_pulse_out !== prevPulse) tog++;
      if (wb_ack_o === 1'b1 && !wb_we_i) check("rdata", wb_dat_o, expQ.pop_front());
      if (cycles == 80000) begin
         n_fail++;
         finish_test();
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(logic we, logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      bus(1, a, d);
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] e);
      expQ.push_back(e);
      bus(0, a, 0);
   endtask
   task automatic wait_n(int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task automatic pulses(int e);
      int t0;
      wait_n(20);
      t0 = tog;
      wait_n(3000);
      check("toggles", tog - t0, e);
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      sense_amp_out_a <= 12'($random(seed));
      sense_amp_out_b <= 12'($random(seed));
      sense_amp_out_c <= 12'($random(seed));
      repeat (4) @(posedge ref_clk);
      rstn <= 1;
      for (int i = 0; i < 8; i++) rd(8'(i * 4), RV[i]);
      rd(8'h30, 0);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         wr(REG_CTRL, 32'((i % 3) * 5));
         dirPin <= 1'($random(seed));
         brakePin <= 1'($random(seed));
         wait_n(2);
         check("dir", dirCounterClockwise, i % 3 == 1 ? 0 : i % 3 == 2 ? 1 : dirPin);
         check("brake", brakeActive, i % 3 == 1 ? 1 : i % 3 == 2 ? 0 : brakePin);
      end
      wr(REG_SPEED_CFG, 32'h0000_012D);
      wait_n(700);
      rd(REG_PERIOD, 32'h0100_012C);
      rd(REG_FAULT, 1);
      wr(REG_SPEED_CFG, 32'h0000_012C);
      wait_n(700);
      rd(REG_FAULT, 1);
      wr(REG_FAULT, 1);
      rd(REG_FAULT, 0);
      wr(REG_SYNC_TIMEOUT, 50);
      spinning <= 0;
      wait_n(60);
      rd(REG_FAULT, 2);
      wr(REG_SYNC_TIMEOUT, RST_SYNC_TIMEOUT);
      spinning <= 1;
      wr(REG_FAULT, 2);
      rd(REG_FAULT, 0);
      phaseCurrent <= 12'h0066;
      wait_n(3);
      rd(REG_FAULT, 4);
      phaseCurrent <= 12'h0067;
      wr(REG_FAULT, 4);
      rd(REG_FAULT, 0);
      supplyVoltage <= 9'h028;
      wait_n(3);
      rd(REG_FAULT, 8);
      rd(REG_STATUS, 3);
      supplyVoltage <= 9'h168;
      wait_n(3);
      rd(REG_FAULT, 32'h0000_0010);
      supplyVoltage <= 9'h0B4;
      wait_n(3);
      rd(REG_FAULT, 0);
      wr(REG_CTRL, 32'h0000_0180);
      supplyVoltage <= 9'h028;
      repeat (3) @(posedge ref_clk);
      supplyVoltage <= 9'h168;
      repeat (3) @(posedge ref_clk);
      supplyVoltage <= 9'h0B4;
      wait_n(3);
      rd(REG_FAULT, 32'h0000_0018);
      wr(REG_FAULT, 32'h0000_0018);
      rd(REG_FAULT, 0);
      $display("test faults done");
      wr(REG_MONITOR_SEL, 32'h0002_0001);
      wait_n(3);
      check("dacA", monitor_dac_a, phaseCurrent);
      check("dacB", monitor_dac_b, supplyVoltage);
      wr(REG_MONITOR_SEL, 32'h0004_0000);
      wait_n(3);
      check("dacAper", monitor_dac_a, 32'h0000_012C);
      check("dacBemf", monitor_dac_b, backEmfLevel);
      for (int s = 1; s < 4; s++) begin
         wr(REG_CTRL, 32'(s << 10));
         wait_n(3);
         check("pinB", monitor_dac_b, s == 1 ? sense_amp_out_a : s == 2 ? sense_amp_out_b :
            sense_amp_out_c);
      end
      wr(REG_PULSE_CFG, 32'h0001_0002);
      for (int i = 0; i < 6; i++) begin
         wr(REG_CTRL, 32'(i % 3) << 4);
         closedLoop <= i < 3;
         openLoop <= i >= 3;
         pulses(i % 3 == 1 || i == 0 || i == 5 ? 5 : 0);
      end
      wr(REG_CTRL, 0);
      closedLoop <= 1;
      openLoop <= 0;
      motorDriven <= 0;
      pulses(0);
      check("idle", speed_pulse_out, 0);
      wr(REG_CTRL, 32'h0000_0040);
      pulses(5);
      wr(REG_PULSE_CFG, 32'h0003_0002);
      pulses(0);
      $display("test pulse done");
      wr(REG_CTRL, 32'h0000_1000);
      motorDriven <= 1;
      wr(REG_SLEEP_TIME, 30);
      wr(REG_SPEED_CFG, 32'h0200_0000);
      speedInput <= 12'h000A;
      wait_n(40);
      check("sleep", {motorOutEnable, chargePumpEnable, analog_regulator, serialEnable}, 0);
      rd(REG_STATUS, 8);
      speedInput <= 12'h0064;
      wait_n(3);
      rd(REG_STATUS, 2);
      wr(REG_CTRL, 0);
      speedInput <= 12'h000A;
      wait_n(40);
      check("standby", {motorOutEnable, chargePumpEnable, analog_regulator, serialEnable}, 7);
      rd(REG_STATUS, 4);
      $display("test power done");
      finish_test();
   end
endmodule // msc_supervisor_test
